// File: aifr_chk.sv
// Purpose: Concurrent checks on the ports of the identify and flush responder.
// Assumes: One clock domain; reset_n is synchronous and active low.
// Notes:   Bound to every aifr_top instance by the statement at the foot.
module aifr_chk #(
	parameter int DEPTH = 8
) (
	input wire logic                   mclk,
	input wire logic                   reset_n,
	input wire logic                   cmd_valid,
	input wire logic [7:0]             cmd_opcode,
	input wire logic                   cmd_ready,
	input wire aifr_pkg::aifr_ident_t  ident,
	input wire aifr_pkg::aifr_status_t status,
	input wire logic                   intrq,
	input wire logic                   flush_req,
	input wire logic                   flush_done,
	input wire logic                   flush_err,
	input wire logic                   data_valid,
	input wire logic                   data_ready,
	input wire logic [15:0]            data_word
);
	timeunit 1ns;
	timeprecision 1ps;

	// Bound on the fill before the data request: one load, DEPTH pushes, the staging edge and two spare cycles.
	localparam int FILL_MAX = DEPTH + 4;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	// A command is taken on this edge; words taken since the last command are counted.
	logic       take;
	logic [8:0] word_cnt_reg;
	logic [8:0] word_cnt_next;
	assign take = cmd_valid && cmd_ready;
	assign word_cnt_next = take ? 9'h000 : word_cnt_reg + {8'h00, data_valid && data_ready};

	// Counter of identify words handed to the host.
	always_ff @(posedge mclk) begin
		word_cnt_reg <= reset_n ? word_cnt_next : 9'h000;
	end

	flush_start_a: assert property (take && (cmd_opcode == 8'hE7 || cmd_opcode == 8'hEA) |=>
		flush_req && status.bsy) else $error("flush not started");
	flush_busy_a: assert property (flush_req && !flush_done && !flush_err |=>
		status.bsy && flush_req) else $error("busy dropped during flush");
	flush_end_a: assert property (flush_req && (flush_done || flush_err) |=>
		!status.bsy && !flush_req && intrq && status.err == $past(flush_err))
		else $error("flush did not end cleanly");
	format_run_a: assert property (take && cmd_opcode == 8'h50 |=> status.bsy && !intrq
		##1 !status.bsy && intrq && !status.err) else $error("format track mishandled");
	ident_stage_a: assert property (take && cmd_opcode == 8'hEC |=> status.bsy && !status.drq
		##[1:FILL_MAX] status.drq) else $error("identify never raised data request");
	drq_rise_a: assert property ($rose(status.drq) |-> intrq && !status.bsy && data_valid)
		else $error("data request without interrupt");
	intrq_pulse_a: assert property (intrq |=> !intrq) else $error("interrupt longer than a cycle");
	word_hold_a: assert property (data_valid && !data_ready |=> data_valid && $stable(data_word))
		else $error("data word changed before it was read");
	valid_drq_a: assert property (data_valid |-> status.drq) else $error("data outside request");
	last_word_a: assert property (data_valid && data_ready && word_cnt_reg == 9'h0FF |=>
		!status.drq && cmd_ready && !data_valid) else $error("no idle after last word");
endmodule

bind aifr_top aifr_chk #(.DEPTH(DEPTH)) chk (.mclk(mclk), .reset_n(reset_n),
	.cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_ready(cmd_ready), .ident(ident),
	.status(status), .intrq(intrq), .flush_req(flush_req), .flush_done(flush_done),
	.flush_err(flush_err), .data_valid(data_valid), .data_ready(data_ready),
	.data_word(data_word));

// File: aifr_host_model.sv
// Purpose: Host side that reads identify words from the data port.
// Assumes: Outputs change 1 ns after the rising edge of mclk.
// Notes:   With stall_en set, reads are withheld on random cycles.
module aifr_host_model (
	input  wire logic mclk,
	input  wire logic reset_n,
	input  wire logic stall_en,
	output logic      data_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 62;

	// Reads one word per ready cycle, stalling at random when asked.
	initial data_ready = 1'b0;
	always @(posedge mclk) begin
		data_ready <= #1 reset_n && (!stall_en || ($random(seed) & 1) == 0);
	end
endmodule

// File: aifr_pkg.sv
// Purpose: Shared constants and types for the ATA identify and flush responder.
// Assumes: One clock, mclk at 250 MHz, synchronous active-low reset.
// Notes:   Identify words are built on the fly from the configuration struct.
package aifr_pkg;

	// Command opcodes.
	localparam logic [7:0] OP_FLUSH      = 8'hE7;
	localparam logic [7:0] OP_FLUSH_EXT  = 8'hEA;
	localparam logic [7:0] OP_FORMAT_TRK = 8'h50;
	localparam logic [7:0] OP_IDENTIFY   = 8'hEC;

	// Identify block geometry.
	localparam int          ID_WORDS      = 256;
	localparam logic [8:0]  ID_LAST       = 9'h0FF;
	localparam int          FIFO_DEPTH    = 8;

	// Word indices with fixed or sourced content.
	localparam logic [7:0]  W_GENCFG   = 8'h00;
	localparam logic [7:0]  W_CYL      = 8'h01;
	localparam logic [7:0]  W_HEADS    = 8'h03;
	localparam logic [7:0]  W_SPT      = 8'h06;
	localparam logic [7:0]  W_SN_FIRST = 8'h0A;
	localparam logic [7:0]  W_SN_LAST  = 8'h13;
	localparam logic [7:0]  W_RET21    = 8'h15;
	localparam logic [7:0]  W_ECC      = 8'h16;
	localparam logic [7:0]  W_FW_FIRST = 8'h17;
	localparam logic [7:0]  W_FW_LAST  = 8'h1A;
	localparam logic [7:0]  W_MN_FIRST = 8'h1B;
	localparam logic [7:0]  W_MN_LAST  = 8'h2E;
	localparam logic [7:0]  W_MULT     = 8'h2F;
	localparam logic [7:0]  W_RES48    = 8'h30;
	localparam logic [7:0]  W_CAP      = 8'h31;
	localparam logic [7:0]  W_CAP2     = 8'h32;
	localparam logic [7:0]  W_PIO_TM   = 8'h33;
	localparam logic [7:0]  W_DMA_TM   = 8'h34;
	localparam logic [7:0]  W_VALID    = 8'h35;
	localparam logic [7:0]  W_LBA_LO   = 8'h3C;
	localparam logic [7:0]  W_LBA_HI   = 8'h3D;

	// Fixed word values.
	localparam logic [15:0] V_GENCFG   = 16'h0040;
	localparam logic [15:0] V_SPT      = 16'h003F;
	localparam logic [15:0] V_4000     = 16'h4000;
	localparam logic [15:0] V_ECC      = 16'h0004;
	localparam logic [7:0]  V_MULT_HI  = 8'h80;
	localparam logic [15:0] V_CAP      = 16'h2F00;
	localparam logic [15:0] V_TIMING   = 16'h0200;
	localparam logic [15:0] V_VALID    = 16'h0007;

	// Drive identity and geometry as reported by identify.
	typedef struct packed {
		logic [15:0]  cylinders;
		logic [7:0]   heads;
		logic [7:0]   max_multiple;
		logic [31:0]  total_sectors;
		logic [159:0] serial;
		logic [63:0]  firmware;
		logic [319:0] model;
	} aifr_ident_t;

	// Command status seen by the host.
	typedef struct packed {
		logic bsy;
		logic drq;
		logic err;
	} aifr_status_t;

endpackage

// File: aifr_top.sv
// Purpose: Command handling for flush cache, format track and identify device.
// Assumes: Host-side and cache-side logic share mclk; no input needs synchronising.
// Notes:   An 8-word FIFO carries identify words from the generator to the host.

// Parameterised FIFO with valid and ready on both sides.
module aifr_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             flush
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
			$error("aifr_fifo depth must be a power of two of at least 2.");
		end
	endgenerate

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// Handshake decode; full and empty come straight from the count.
	assign in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid = (count_reg != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_reg[rd_ptr_reg];

	// Storage write.
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// Pointer and count update; flush empties the queue.
	always_ff @(posedge mclk) begin
		if (!reset_n || flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// Command interpreter and identify block generator.
module aifr_top #(
	parameter int DEPTH = aifr_pkg::FIFO_DEPTH
) (
	input  wire logic                 mclk,
	input  wire logic                 reset_n,
	input  wire logic                 cmd_valid,
	input  wire logic [7:0]           cmd_opcode,
	output logic                      cmd_ready,
	input  wire aifr_pkg::aifr_ident_t ident,
	output aifr_pkg::aifr_status_t    status,
	output logic                      intrq,
	output logic                      flush_req,
	input  wire logic                 flush_done,
	input  wire logic                 flush_err,
	output logic                      data_valid,
	input  wire logic                 data_ready,
	output logic [15:0]               data_word
);
	typedef enum logic [2:0] {
		AIFR_IDLE,
		AIFR_FLUSH,
		AIFR_FORMAT,
		AIFR_ID_FILL,
		AIFR_ID_XFER
	} aifr_state_t;

	generate
		if (DEPTH < 2 || DEPTH > aifr_pkg::ID_WORDS) begin : g_bad_depth
			$error("aifr_top FIFO depth must lie between 2 and 256.");
		end
	endgenerate

	// Picks word k of a packed string whose first character is in the top byte.
	function automatic logic [15:0] str_word(input logic [319:0] s, input int nwords,
	                                         input logic [7:0] k);
		logic [8:0] sh;
		sh = 9'(nwords - 1 - int'(k)) << 4;
		return 16'(s >> sh);
	endfunction

	// Builds the identify word at index idx; all unlisted words read zero.
	function automatic logic [15:0] id_word(input logic [7:0] idx,
	                                        input aifr_pkg::aifr_ident_t id);
		logic [15:0] w;
		w = 16'h0000;
		if (idx == aifr_pkg::W_GENCFG) begin
			w = aifr_pkg::V_GENCFG;
		end else if (idx == aifr_pkg::W_CYL) begin
			w = id.cylinders;
		end else if (idx == aifr_pkg::W_HEADS) begin
			w = {8'h00, id.heads};
		end else if (idx == aifr_pkg::W_SPT) begin
			w = aifr_pkg::V_SPT;
		end else if (idx >= aifr_pkg::W_SN_FIRST && idx <= aifr_pkg::W_SN_LAST) begin
			w = str_word({160'h0, id.serial}, 10, idx - aifr_pkg::W_SN_FIRST);
		end else if (idx == aifr_pkg::W_RET21 || idx == aifr_pkg::W_RES48
		             || idx == aifr_pkg::W_CAP2) begin
			w = aifr_pkg::V_4000;
		end else if (idx == aifr_pkg::W_ECC) begin
			w = aifr_pkg::V_ECC;
		end else if (idx >= aifr_pkg::W_FW_FIRST && idx <= aifr_pkg::W_FW_LAST) begin
			w = str_word({256'h0, id.firmware}, 4, idx - aifr_pkg::W_FW_FIRST);
		end else if (idx >= aifr_pkg::W_MN_FIRST && idx <= aifr_pkg::W_MN_LAST) begin
			w = str_word(id.model, 20, idx - aifr_pkg::W_MN_FIRST);
		end else if (idx == aifr_pkg::W_MULT) begin
			w = {aifr_pkg::V_MULT_HI, id.max_multiple};
		end else if (idx == aifr_pkg::W_CAP) begin
			w = aifr_pkg::V_CAP;
		end else if (idx == aifr_pkg::W_PIO_TM || idx == aifr_pkg::W_DMA_TM) begin
			w = aifr_pkg::V_TIMING;
		end else if (idx == aifr_pkg::W_VALID) begin
			w = aifr_pkg::V_VALID;
		end else if (idx == aifr_pkg::W_LBA_LO) begin
			w = id.total_sectors[15:0];
		end else if (idx == aifr_pkg::W_LBA_HI) begin
			w = id.total_sectors[31:16];
		end
		return w;
	endfunction

	aifr_state_t state_reg;
	aifr_state_t state_next;
	logic [8:0]  gen_idx_reg;
	logic [8:0]  rd_cnt_reg;
	logic        gen_done_reg;
	logic        bsy_reg;
	logic        drq_reg;
	logic        err_reg;
	logic        intrq_reg;
	logic        flush_req_reg;
	logic [15:0] gen_word_reg;
	logic        gen_valid_reg;

	wire         cmd_take;
	wire         is_flush;
	wire         is_format;
	wire         is_identify;
	wire         fifo_in_ready;
	wire         fifo_out_valid;
	wire         host_take;
	wire         gen_push;
	wire         gen_load;
	wire         last_read;
	wire         staged;
	wire         in_id;

	// Command decode; both flush opcodes map to the same action.
	assign cmd_ready   = (state_reg == AIFR_IDLE);
	assign cmd_take    = cmd_valid && cmd_ready;
	assign is_flush    = (cmd_opcode == aifr_pkg::OP_FLUSH)
	                     || (cmd_opcode == aifr_pkg::OP_FLUSH_EXT);
	assign is_format   = (cmd_opcode == aifr_pkg::OP_FORMAT_TRK);
	assign is_identify = (cmd_opcode == aifr_pkg::OP_IDENTIFY);

	// Identify data path terms.
	assign in_id      = (state_reg == AIFR_ID_FILL) || (state_reg == AIFR_ID_XFER);
	assign gen_push   = gen_valid_reg && fifo_in_ready;
	assign gen_load   = in_id && !gen_done_reg && (!gen_valid_reg || gen_push);
	assign host_take  = (state_reg == AIFR_ID_XFER) && fifo_out_valid && data_ready;
	assign last_read  = host_take && (rd_cnt_reg == aifr_pkg::ID_LAST);
	// Staged once the FIFO is full or the whole block has been queued.
	assign staged     = !fifo_in_ready || (gen_done_reg && !gen_valid_reg);
	assign data_valid = (state_reg == AIFR_ID_XFER) && fifo_out_valid;

	assign status    = '{bsy: bsy_reg, drq: drq_reg, err: err_reg};
	assign intrq     = intrq_reg;
	assign flush_req = flush_req_reg;

	aifr_fifo #(
		.WIDTH (16),
		.DEPTH (DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.in_valid  (gen_valid_reg),
		.in_ready  (fifo_in_ready),
		.in_data   (gen_word_reg),
		.out_valid (fifo_out_valid),
		.out_ready (host_take),
		.out_data  (data_word),
		.flush     (state_reg == AIFR_IDLE)
	);

	// Next state selection.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			AIFR_IDLE: begin
				if (cmd_take && is_flush) begin
					state_next = AIFR_FLUSH;
				end else if (cmd_take && is_format) begin
					state_next = AIFR_FORMAT;
				end else if (cmd_take && is_identify) begin
					state_next = AIFR_ID_FILL;
				end
			end
			AIFR_FLUSH: begin
				if (flush_done || flush_err) begin
					state_next = AIFR_IDLE;
				end
			end
			AIFR_FORMAT: begin
				state_next = AIFR_IDLE;
			end
			AIFR_ID_FILL: begin
				if (staged) begin
					state_next = AIFR_ID_XFER;
				end
			end
			AIFR_ID_XFER: begin
				if (last_read) begin
					state_next = AIFR_IDLE;
				end
			end
			default: begin
				state_next = AIFR_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_reg <= AIFR_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Word generator: one word queued per free slot, index counts to 256.
	always_ff @(posedge mclk) begin
		if (!reset_n || !in_id) begin
			gen_idx_reg   <= '0;
			gen_done_reg  <= 1'b0;
			gen_valid_reg <= 1'b0;
			gen_word_reg  <= 16'h0000;
		end else if (gen_load) begin
			gen_word_reg  <= id_word(gen_idx_reg[7:0], ident);
			gen_valid_reg <= 1'b1;
			gen_idx_reg   <= gen_idx_reg + 9'h001;
			gen_done_reg  <= (gen_idx_reg == aifr_pkg::ID_LAST);
		end else if (gen_push) begin
			gen_valid_reg <= 1'b0;
		end
	end

	// Count of words the host has read.
	always_ff @(posedge mclk) begin
		if (!reset_n || !in_id) begin
			rd_cnt_reg <= '0;
		end else if (host_take) begin
			rd_cnt_reg <= rd_cnt_reg + 9'h001;
		end
	end

	// Cache flush request held until the cache reports completion or failure.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			flush_req_reg <= 1'b0;
		end else if (state_next == AIFR_FLUSH) begin
			flush_req_reg <= 1'b1;
		end else begin
			flush_req_reg <= 1'b0;
		end
	end

	// BSY while a command runs up to its data phase; DRQ during the data phase; one-cycle interrupt when DRQ rises or a non-identify command ends.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			bsy_reg   <= 1'b0;
			drq_reg   <= 1'b0;
			err_reg   <= 1'b0;
			intrq_reg <= 1'b0;
		end else begin
			bsy_reg   <= (state_next == AIFR_FLUSH) || (state_next == AIFR_FORMAT)
			             || (state_next == AIFR_ID_FILL);
			drq_reg   <= (state_next == AIFR_ID_XFER);
			intrq_reg <= ((state_reg == AIFR_FLUSH) && (flush_done || flush_err))
			             || (state_reg == AIFR_FORMAT)
			             || ((state_reg == AIFR_ID_FILL) && staged)
			             || (cmd_take && !is_flush && !is_format && !is_identify);
			if (cmd_take) begin
				err_reg <= !(is_flush || is_format || is_identify);
			end else if (state_reg == AIFR_FLUSH && flush_err) begin
				err_reg <= 1'b1;
			end
		end
	end
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench for the identify and flush responder.
// Assumes: Inputs change 1 ns after the rising edge; outputs are read on falling edges.
// Notes:   Identify words expected are queued by the driver and checked by a monitor.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                   mclk, reset_n, cmd_valid, cmd_ready, intrq, flush_req;
	logic                   flush_done, flush_err, data_valid, data_ready, stall_en;
	logic [7:0]             cmd_opcode;
	logic [15:0]            data_word;
	logic [607:0]           rnd;
	aifr_pkg::aifr_ident_t  ident;
	aifr_pkg::aifr_status_t status;
	logic [15:0]            exp_q[$];
	int                     bad_count = 0, checks = 0, intr_cnt = 0, seed = 62;

	aifr_top #(.DEPTH(8)) dut (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid),
		.cmd_opcode(cmd_opcode), .cmd_ready(cmd_ready), .ident(ident), .status(status),
		.intrq(intrq), .flush_req(flush_req), .flush_done(flush_done), .flush_err(flush_err),
		.data_valid(data_valid), .data_ready(data_ready), .data_word(data_word));
	aifr_host_model host (.mclk(mclk), .reset_n(reset_n), .stall_en(stall_en),
		.data_ready(data_ready));

	// Clock at 250 MHz.
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (bad_count == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Expected identify word at index k for identity id.
	function automatic logic [15:0] exp_word(input int k, input aifr_pkg::aifr_ident_t id);
		if (k == 0) return 16'h0040;
		if (k == 1) return id.cylinders;
		if (k == 3) return {8'h00, id.heads};
		if (k == 6) return 16'h003F;
		if (k >= 10 && k <= 19) return id.serial[159 - 16 * (k - 10) -: 16];
		if (k == 21 || k == 48 || k == 50) return 16'h4000;
		if (k == 22) return 16'h0004;
		if (k >= 23 && k <= 26) return id.firmware[63 - 16 * (k - 23) -: 16];
		if (k >= 27 && k <= 46) return id.model[319 - 16 * (k - 27) -: 16];
		if (k == 47) return {8'h80, id.max_multiple};
		if (k == 49) return 16'h2F00;
		if (k == 51 || k == 52) return 16'h0200;
		if (k == 53) return 16'h0007;
		if (k == 60) return id.total_sectors[15:0];
		if (k == 61) return id.total_sectors[31:16];
		return 16'h0000;
	endfunction

	task automatic wait_idle(input int lim);
		int n;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (cmd_ready !== 1'b1 && n < lim);
		if (cmd_ready !== 1'b1) begin
			bad_count++;
			$display("[FAIL] %0t wait for idle ran out", $time);
			finish_test();
		end
	endtask

	// Offers one command and finishes it; the cache side answers flushes after dly cycles.
	task automatic run(input logic [7:0] op, input logic fail, input int dly, input logic e_err);
		int n0;
		n0 = intr_cnt;
		if (op == 8'hEC) for (int k = 0; k < 256; k++) exp_q.push_back(exp_word(k, ident));
		@(posedge mclk);
		#1;
		cmd_valid = 1'b1;
		cmd_opcode = op;
		wait_idle(50);
		@(posedge mclk);
		#1;
		cmd_valid = 1'b0;
		if (op == 8'hE7 || op == 8'hEA) begin
			repeat (dly) @(negedge mclk);
			check(16'({status.bsy, flush_req}), 16'h0003);
			@(posedge mclk);
			#1;
			flush_done = !fail;
			flush_err = fail;
			@(posedge mclk);
			#1;
			flush_done = 1'b0;
			flush_err = 1'b0;
		end
		wait_idle(3000);
		repeat (2) @(negedge mclk);
		check(16'(intr_cnt - n0), 16'h0001);
		check(16'(status.err), 16'(e_err));
		check(16'(exp_q.size()), 16'h0000);
	endtask

	// Counts interrupts and compares each word taken with the oldest expected one.
	always @(negedge mclk) begin
		if (reset_n && intrq) intr_cnt++;
		if (reset_n && data_valid && data_ready) begin
			check(data_word, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
		end
	end

	// Ends a hung run.
	initial begin
		repeat (100000) @(posedge mclk);
		bad_count++;
		$display("[FAIL] %0t run too long", $time);
		finish_test();
	end

	// Main sequence: reset, flushes with and without error, unknown, format, identify with stalls, identify without stalls.
	initial begin
		reset_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_opcode = 8'h00;
		flush_done = 1'b0;
		flush_err = 1'b0;
		stall_en = 1'b1;
		ident = '0;
		repeat (16) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		@(negedge mclk);
		check(16'({cmd_ready, status, intrq, flush_req, data_valid}), 16'h0040);
		for (int i = 0; i < 19; i++) rnd[i * 32 +: 32] = $random(seed);
		@(posedge mclk);
		#1;
		ident = rnd;
		for (int i = 0; i < 4; i++) run(i[0] ? 8'hEA : 8'hE7, i[1], 1 + ($random(seed) & 15), i[1]);
		run(8'h00, 1'b0, 0, 1'b1);
		run(8'h50, 1'b0, 0, 1'b0);
		run(8'hEC, 1'b0, 0, 1'b0);
		@(posedge mclk);
		#1;
		stall_en = 1'b0;
		ident = '0;
		run(8'hEC, 1'b0, 0, 1'b0);
		finish_test();
	end
endmodule
